// >>> ston_defines.vh
// constants shared by the safety timer operator block
// assumes a 200 MHz pclk and APB word access
`ifndef STON_DEFINES_VH
`define STON_DEFINES_VH

`define STON_CLK_MHZ 200
`define STON_BASE_MS 10
`define STON_BASE_CYC (`STON_BASE_MS * `STON_CLK_MHZ * 1000)
`define STON_SLOW_MS 500
`define STON_SLOW_DIV (`STON_SLOW_MS / `STON_BASE_MS)

// durations are held in base units: 10 ms short range, 0.5 s long range
`define STON_T_MIN 17'h00001
`define STON_T_MAX 17'h1ad06
`define STON_THR_MAX 17'h1acfc
`define STON_CLK_T_MIN 17'h0000a
`define STON_FINE_MAX 17'h01770
`define STON_COARSE_STEP 17'h0000a
`define STON_T_RST 17'h00064
`define STON_PULSE_TICKS 2'h2

`define STON_REG_CFG 4'h0
`define STON_REG_T_OS 4'h1
`define STON_REG_T_CMP 4'h8
`define STON_REG_T_CLK 4'h9
`define STON_REG_STAT 4'ha
`define STON_REG_VAL 4'hb

`define STON_CFG_OS_RISE 0
`define STON_CFG_PMC_RETRIG 4
`define STON_CFG_DLY_RISE 5
`define STON_CFG_VAL_EN 9
`define STON_CFG_MASK 32'h000003ff
`define STON_CFG_RST 32'h000000a5

`endif

// >>> ston_tick.v
// time base: one pulse per 10 ms and one per 0.5 s
// assumes a free-running pclk; the slow pulse lands on a fast one
`timescale 1ns/1ps
`default_nettype none
`include "ston_defines.vh"

module ston_tick #(
    parameter BASE_CYC = `STON_BASE_CYC
) (
    input wire pclk,
    input wire presetn,
    output reg tick_fast_ff,
    output reg tick_slow_ff
);

reg [31:0] div_ff;
reg [7:0] slow_ff;

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        div_ff <= 32'h0;
        slow_ff <= 8'h0;
        tick_fast_ff <= 1'b0;
        tick_slow_ff <= 1'b0;
    end
    else if (div_ff == BASE_CYC - 1)
    begin
        div_ff <= 32'h0;
        tick_fast_ff <= 1'b1;
        tick_slow_ff <= (slow_ff == `STON_SLOW_DIV - 1);
        slow_ff <= (slow_ff == `STON_SLOW_DIV - 1) ? 8'h0 : slow_ff + 8'h1;
    end
    else
    begin
        div_ff <= div_ff + 32'h1;
        tick_fast_ff <= 1'b0;
        tick_slow_ff <= 1'b0;
    end
end

endmodule
`default_nettype wire

// >>> ston_clkgen.v
// square-wave generator with selectable duty cycle
// assumes period in 10 ms units and a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
`include "ston_defines.vh"

module ston_clkgen (
    input wire pclk,
    input wire presetn,
    input wire tick,
    input wire en,
    input wire [6:0] duty_sel,
    input wire [16:0] period,
    output reg wave_ff
);

reg [16:0] phase_ff;
reg [16:0] nxt_phase;
wire [3:0] tenths;
wire [20:0] prod;
wire [20:0] hi_w;

// unlisted combinations fall back to 50%, upstream must avoid them
function [3:0] duty;
    input [6:0] sel;
    begin
        case (sel)
            7'h01: duty = 4'h1;
            7'h02: duty = 4'h2;
            7'h04: duty = 4'h3;
            7'h08: duty = 4'h4;
            7'h10: duty = 4'h6;
            7'h20: duty = 4'h7;
            7'h40: duty = 4'h8;
            7'h41: duty = 4'h9;
            default: duty = 4'h5;
        endcase
    end
endfunction

assign tenths = duty(duty_sel);
assign prod = period * tenths;
assign hi_w = prod / 21'h00000a;

always @*
begin
    nxt_phase = phase_ff + 17'h1;
    if (nxt_phase >= period)
        nxt_phase = 17'h0;
end

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        phase_ff <= 17'h0;
        wave_ff <= 1'b0;
    end
    else if (!en)
    begin
        phase_ff <= 17'h0;
        wave_ff <= 1'b0;
    end
    else
    begin
        if (tick)
            phase_ff <= nxt_phase;
        wave_ff <= (phase_ff < hi_w[16:0]);
    end
end

endmodule
`default_nettype wire

// >>> ston_top.v
// timer operator family behind an APB register file
// assumes operator inputs come from logic on pclk; no sync needed
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ston_defines.vh"

module ston_top #(
    parameter BASE_CYC = `STON_BASE_CYC
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [6:0] op_in,
    input wire clk_en,
    input wire [6:0] duty_sel,
    output reg [7:0] op_out,
    output wire clk_out,
    output reg [16:0] timer_value
);

reg [31:0] cfg_ff;
reg [16:0] tim_ff [1:9];
reg [6:0] in_prev_ff;
reg [31:0] rd_w;
wire tick_fast;
wire tick_slow;
wire [6:0] rise_w;
wire [6:0] fall_w;
wire [3:0] idx;
wire mapped;
wire setup;
wire access;
wire [1:0] osq;
wire [1:0] dq;
wire [1:0] dlq;
wire [16:0] ldly_cnt;
integer i;

// clamp to range, then snap to the coarse step above the fine range
function [16:0] quant;
    input [31:0] v;
    input [16:0] lo;
    input [16:0] hi;
    reg [16:0] x;
    begin
        x = 17'h0;
        if (v > {15'h0, hi})
            x = hi;
        else if (v < {15'h0, lo})
            x = lo;
        else
            x = v[16:0];
        if (x > `STON_FINE_MAX)
            x = x - (x % `STON_COARSE_STEP);
        quant = x;
    end
endfunction

function expire;
    input tick;
    input [16:0] cnt;
    input [16:0] t;
    begin
        expire = tick && ({1'b0, cnt} + 18'h1 >= {1'b0, t});
    end
endfunction

ston_tick #(
    .BASE_CYC(BASE_CYC)
) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick_fast_ff(tick_fast),
    .tick_slow_ff(tick_slow)
);

ston_clkgen u_clkgen (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick_fast),
    .en(clk_en),
    .duty_sel(duty_sel),
    .period(tim_ff[`STON_REG_T_CLK]),
    .wave_ff(clk_out)
);

assign rise_w = op_in & ~in_prev_ff;
assign fall_w = ~op_in & in_prev_ff;
assign idx = paddr[5:2];
assign mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0) &&
    (idx <= `STON_REG_VAL);
assign setup = psel & ~penable;
assign access = psel & penable & pready;

always @*
begin
    rd_w = 32'h0;
    if (idx == `STON_REG_CFG)
        rd_w = cfg_ff & `STON_CFG_MASK;
    else if (idx <= `STON_REG_T_CLK)
        rd_w = {15'h0, tim_ff[idx]};
    else if (idx == `STON_REG_STAT)
        rd_w = {16'h0, op_out, clk_out, op_in};
    else if (idx == `STON_REG_VAL)
        rd_w = {15'h0, timer_value};
end

// answer is ready in the first access cycle, so no wait states
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0;
        cfg_ff <= `STON_CFG_RST;
        for (i = 1; i <= 9; i = i + 1)
            tim_ff[i] <= `STON_T_RST;
        in_prev_ff <= 7'h0;
    end
    else
    begin
        in_prev_ff <= op_in;
        pready <= setup;
        if (setup)
        begin
            pslverr <= ~mapped;
            prdata <= (mapped && !pwrite) ? rd_w : 32'h0;
        end
        if (access && pwrite && mapped)
        begin
            if (idx == `STON_REG_CFG)
                cfg_ff <= pwdata & `STON_CFG_MASK;
            else if (idx == `STON_REG_T_CMP)
                tim_ff[idx] <= quant(pwdata, `STON_T_MIN, `STON_THR_MAX);
            else if (idx == `STON_REG_T_CLK)
                tim_ff[idx] <= quant(pwdata, `STON_CLK_T_MIN, `STON_T_MAX);
            else if (idx < `STON_REG_T_CMP)
                tim_ff[idx] <= quant(pwdata, `STON_T_MIN, `STON_T_MAX);
        end
    end
end

// g = 0 one-shot, g = 1 bounded one-shot
genvar g;
generate
for (g = 0; g < 2; g = g + 1)
begin : g_os
    reg act_ff;
    reg [16:0] cnt_ff;
    wire rmode = cfg_ff[`STON_CFG_OS_RISE + 2 * g];
    wire retrig = cfg_ff[`STON_CFG_OS_RISE + 2 * g + 1];
    wire vin = rmode ? op_in[g] : ~op_in[g];
    wire trig = rmode ? rise_w[g] : fall_w[g];
    wire chg = rise_w[g] | fall_w[g];
    wire done = expire(tick_fast, cnt_ff, tim_ff[`STON_REG_T_OS + g]);
    wire restart = (trig & (~act_ff | retrig)) |
        ((g == 0) & act_ff & retrig & chg);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            act_ff <= 1'b0;
            cnt_ff <= 17'h0;
        end
        else if (restart)
        begin
            act_ff <= 1'b1;
            cnt_ff <= 17'h0;
        end
        else if (act_ff && tick_fast)
        begin
            if (done && ((g == 1) || !vin))
                act_ff <= 1'b0;
            if (!done)
                cnt_ff <= cnt_ff + 17'h1;
        end
    end
    assign osq[g] = rmode ? act_ff : ~act_ff;
end
endgenerate

reg pmc_run_ff;
reg pmc_exp_ff;
reg pmc_hold_ff;
reg [16:0] pmc_cnt_ff;
wire pmc_retrig = cfg_ff[`STON_CFG_PMC_RETRIG];
wire pmc_done = expire(tick_fast, pmc_cnt_ff, tim_ff[3]);
wire pmc_start = rise_w[2] | (op_in[2] & ~pmc_run_ff & ~pmc_exp_ff);

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pmc_run_ff <= 1'b0;
        pmc_exp_ff <= 1'b0;
        pmc_hold_ff <= 1'b0;
        pmc_cnt_ff <= 17'h0;
    end
    else if (pmc_start)
    begin
        pmc_run_ff <= 1'b1;
        pmc_exp_ff <= 1'b0;
        pmc_hold_ff <= 1'b0;
        pmc_cnt_ff <= 17'h0;
    end
    else if (fall_w[2] && !pmc_retrig)
    begin
        pmc_run_ff <= 1'b0;
        pmc_exp_ff <= 1'b0;
        pmc_cnt_ff <= 17'h0;
    end
    else
    begin
        if (fall_w[2] && pmc_run_ff)
            pmc_hold_ff <= 1'b1;
        if (pmc_run_ff && tick_fast)
        begin
            if (pmc_done)
            begin
                pmc_exp_ff <= 1'b1;
                pmc_run_ff <= 1'b0;
                pmc_hold_ff <= 1'b0;
            end
            else
                pmc_cnt_ff <= pmc_cnt_ff + 17'h1;
        end
    end
end

// g = 0 short delay, g = 1 long delay
generate
for (g = 0; g < 2; g = g + 1)
begin : g_dly
    reg run_ff;
    reg q_ff;
    reg [16:0] cnt_ff;
    wire tk = (g == 1) ? tick_slow : tick_fast;
    wire rmode = cfg_ff[`STON_CFG_DLY_RISE + 2 * g];
    wire retrig = cfg_ff[`STON_CFG_DLY_RISE + 2 * g + 1];
    wire vin = rmode ? op_in[3 + g] : ~op_in[3 + g];
    wire vrise = rmode ? rise_w[3 + g] : fall_w[3 + g];
    wire vfall = rmode ? fall_w[3 + g] : rise_w[3 + g];
    wire chg = rise_w[3 + g] | fall_w[3 + g];
    wire done = expire(tk, cnt_ff, tim_ff[4 + g]);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_ff <= 1'b0;
            q_ff <= 1'b0;
            cnt_ff <= 17'h0;
        end
        else
        begin
            if (vrise || (retrig && chg && run_ff))
            begin
                run_ff <= 1'b1;
                cnt_ff <= 17'h0;
            end
            else if (run_ff && tk)
            begin
                if (done)
                    run_ff <= 1'b0;
                else
                    cnt_ff <= cnt_ff + 17'h1;
            end
            if (vfall)
                q_ff <= 1'b0;
            else if (run_ff && done && vin)
                q_ff <= 1'b1;
        end
    end
    assign dq[g] = rmode ? q_ff : ~q_ff;
end
endgenerate

assign ldly_cnt = g_dly[1].cnt_ff;

// g = 0 short delay line, g = 1 long delay line
generate
for (g = 0; g < 2; g = g + 1)
begin : g_dl
    reg run_ff;
    reg low_ff;
    reg [16:0] cnt_ff;
    reg [1:0] pls_ff;
    wire tk = (g == 1) ? tick_slow : tick_fast;
    wire done = expire(tk, cnt_ff, tim_ff[6 + g]);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_ff <= 1'b0;
            low_ff <= 1'b0;
            cnt_ff <= 17'h0;
            pls_ff <= 2'h0;
        end
        else
        begin
            if (fall_w[5 + g] && !run_ff)
            begin
                run_ff <= 1'b1;
                cnt_ff <= 17'h0;
            end
            else if (run_ff && tk)
            begin
                if (done)
                    run_ff <= 1'b0;
                else
                    cnt_ff <= cnt_ff + 17'h1;
            end
            // low pulse lasts at least two base ticks, even if input is back
            if (run_ff && done)
            begin
                low_ff <= 1'b1;
                pls_ff <= 2'h0;
            end
            else if (low_ff && tick_fast)
            begin
                if (pls_ff + 2'h1 >= `STON_PULSE_TICKS && op_in[5 + g])
                    low_ff <= 1'b0;
                else if (pls_ff + 2'h1 < `STON_PULSE_TICKS)
                    pls_ff <= pls_ff + 2'h1;
            end
        end
    end
    assign dlq[g] = ~low_ff;
end
endgenerate

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        op_out <= 8'h0;
        timer_value <= 17'h0;
    end
    else
    begin
        timer_value <= cfg_ff[`STON_CFG_VAL_EN] ? ldly_cnt : 17'h0;
        op_out[1:0] <= osq;
        op_out[2] <= (op_in[2] & ~pmc_exp_ff) | pmc_hold_ff;
        op_out[4:3] <= dq;
        // fed from the long delay value only
        op_out[5] <= (timer_value >= tim_ff[`STON_REG_T_CMP]);
        op_out[7:6] <= dlq;
    end
end

endmodule
`default_nettype wire

// >>> ston_assertions.sv
// checker on the ports of the timer operator block
// assumes one pclk domain and cfg one-shot rise mode left set
`timescale 1ns/1ps
`default_nettype none
module ston_checker #(
    parameter BASE_CYC = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [6:0] op_in,
    input wire logic clk_en,
    input wire logic [7:0] op_out,
    input wire logic clk_out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_unmapped_err: assert property (psel && !penable &&
        paddr[7:6] != 2'h0 |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_clk_off: assert property (!clk_en [*3] |-> !clk_out)
        else $error("wave runs while disabled");
    a_os_rise: assert property ($rose(op_in[0]) |-> ##2 op_out[0])
        else $error("one-shot did not fire");
    a_os_hold: assert property (op_in[0] [*3] |-> op_out[0])
        else $error("one-shot dropped with input high");
    a_pmc_low: assert property (!op_in[2] [*2] |=> !op_out[2])
        else $error("contact high with input low");
    a_delay_low: assert property (!op_in[3] [*2] |=> !op_out[3])
        else $error("delay high with input low");
    a_line_hold: assert property (op_out[6] && $fell(op_in[5])
        |=> op_out[6])
        else $error("delay line dropped at once");
endmodule
bind ston_top ston_checker #(.BASE_CYC(BASE_CYC)) u_chk (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .op_in(op_in),
    .clk_en(clk_en),
    .op_out(op_out),
    .clk_out(clk_out)
);
`default_nettype wire

// >>> ston_upstream.sv
// upstream logic operators feeding the timer block
// assumes requests from the bench on pclk; adds one cycle
`timescale 1ns/1ps
`default_nettype none
module ston_upstream (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] req_in,
    input wire logic req_en,
    input wire logic [6:0] req_sel,
    output logic [6:0] op_in_ff,
    output logic clk_en_ff,
    output logic [6:0] sel_ff
);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // delay lines idle high so no edge at start
            op_in_ff <= 7'h60;
            clk_en_ff <= 1'b0;
            sel_ff <= 7'h00;
        end
        else
        begin
            op_in_ff <= req_in;
            clk_en_ff <= req_en;
            // only one select, or the 10+80 pair, is ever sent
            if ($onehot0(req_sel) || req_sel == 7'h41)
                sel_ff <= req_sel;
            else
                sel_ff <= 7'h00;
        end
    end
endmodule
`default_nettype wire

// >>> tb_safety_timer_operators.sv
// bench: apb register access and operator stimulus
// assumes BASE_CYC 10: 10 ms tick each 10 cycles, 0.5 s each 500
`timescale 1ns/1ps
`default_nettype none
module tb_safety_timer_operators;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [6:0] req_in = 7'h60;
    logic req_en = 1'b0;
    logic [6:0] req_sel = 7'h00;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic clk_out;
    wire logic clk_en;
    wire logic [6:0] op_in;
    wire logic [6:0] duty_sel;
    wire logic [7:0] op_out;
    wire logic [16:0] timer_value;
    int fails = 0;
    int n_compared = 0;
    logic [6:0] sel_t [9] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08,
        7'h10, 7'h20, 7'h40, 7'h41};
    int duty_t [9] = '{50, 10, 20, 30, 40, 60, 70, 80, 90};
    ston_top #(.BASE_CYC(10)) i_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .op_in(op_in),
        .clk_en(clk_en),
        .duty_sel(duty_sel),
        .op_out(op_out),
        .clk_out(clk_out),
        .timer_value(timer_value)
    );
    ston_upstream i_up (
        .pclk(pclk),
        .presetn(presetn),
        .req_in(req_in),
        .req_en(req_en),
        .req_sel(req_sel),
        .op_in_ff(op_in),
        .clk_en_ff(clk_en),
        .sel_ff(duty_sel)
    );
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("unexpected %s exp %h got %h", s, e, g);
            fails++;
        end
    endtask
    task automatic chk_rng(string s, int lo, int hi, int g);
        n_compared++;
        if (g < lo || g > hi)
        begin
            $display("unexpected %s exp %0d..%0d got %0d", s, lo, hi, g);
            fails++;
        end
    endtask
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            fails++;
            close_out();
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk("reg data", x, q);
    endtask
    task automatic wait_out(int b, logic v, int lim);
        int n;
        n = 0;
        while (op_out[b] !== v && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        chk("op_out bit", {31'h0, v}, {31'h0, op_out[b]});
    endtask
    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rd(8'h00, 32'h000000a5);
        rd(8'h04, 32'h00000064);
        apb(1'b0, 8'h40, 32'h0, q, e);
        chk("slverr", 32'h1, {31'h0, e});
        wr(8'h04, 32'h0);
        rd(8'h04, 32'h00000001);
        wr(8'h04, 32'h0003ffff);
        rd(8'h04, 32'h0001ad06);
        wr(8'h14, 32'h00001771);
        rd(8'h14, 32'h00001770);
        wr(8'h20, 32'h0003ffff);
        rd(8'h20, 32'h0001acfc);
    endtask
    task automatic t_one_shot();
        int n;
        n = 0;
        wr(8'h04, 32'h3);
        req_in[0] <= 1'b1;
        @(posedge pclk);
        req_in[0] <= 1'b0;
        wait_out(0, 1'b1, 8);
        while (op_out[0] === 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        chk_rng("one-shot width", 10, 40, n);
        req_in[0] <= 1'b1;
        repeat (100) @(posedge pclk);
        chk("one-shot held", 32'h1, {31'h0, op_out[0]});
        req_in[0] <= 1'b0;
        wait_out(0, 1'b0, 60);
    endtask
    task automatic t_contact();
        wr(8'h0c, 32'h3);
        req_in[2] <= 1'b1;
        wait_out(2, 1'b1, 8);
        wait_out(2, 1'b0, 60);
        req_in[2] <= 1'b0;
    endtask
    task automatic t_line();
        wr(8'h18, 32'h3);
        req_in[5] <= 1'b0;
        repeat (3) @(posedge pclk);
        req_in[5] <= 1'b1;
        chk("line early", 32'h1, {31'h0, op_out[6]});
        wait_out(6, 1'b0, 60);
        wait_out(6, 1'b1, 60);
        wr(8'h1c, 32'h1);
        req_in[6] <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("long line early", 32'h1, {31'h0, op_out[7]});
        wait_out(7, 1'b0, 1200);
        req_in[6] <= 1'b1;
        wait_out(7, 1'b1, 60);
    endtask
    task automatic t_more();
        wr(8'h08, 32'h3);
        req_in[1] <= 1'b1;
        wait_out(1, 1'b1, 8);
        // input stays high: the bounded pulse must end anyway
        wait_out(1, 1'b0, 60);
        req_in[1] <= 1'b0;
        wr(8'h10, 32'h3);
        req_in[3] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("delay early", 32'h0, {31'h0, op_out[3]});
        wait_out(3, 1'b1, 60);
        req_in[3] <= 1'b0;
        wait_out(3, 1'b0, 10);
    endtask
    task automatic t_compare();
        wr(8'h00, 32'h000002a5);
        wr(8'h14, 32'h4);
        wr(8'h20, 32'h2);
        req_in[4] <= 1'b1;
        wait_out(5, 1'b1, 1500);
        chk("long early", 32'h0, {31'h0, op_out[4]});
        wait_out(4, 1'b1, 1500);
        req_in[4] <= 1'b0;
        wait_out(4, 1'b0, 10);
        wr(8'h00, 32'h000000a5);
        repeat (3) @(posedge pclk);
        chk("timer value", 32'h0, {15'h0, timer_value});
    endtask
    task automatic t_clock();
        int n;
        wr(8'h24, 32'h0000000a);
        for (int i = 0; i < 9; i++)
        begin
            req_sel <= sel_t[i];
            req_en <= 1'b1;
            repeat (100) @(posedge pclk);
            n = 0;
            repeat (1000)
            begin
                @(posedge pclk);
                if (clk_out === 1'b1)
                    n++;
            end
            chk_rng("duty", duty_t[i] * 10 - 20, duty_t[i] * 10 + 20, n);
        end
        req_en <= 1'b0;
        repeat (5) @(posedge pclk);
        chk("wave off", 32'h0, {31'h0, clk_out});
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_one_shot();
        t_contact();
        t_line();
        t_more();
        t_compare();
        t_clock();
        close_out();
    end
endmodule
`default_nettype wire
